// ===== src/power_save_map.vh
// Notes on behaviour
// - Sleep pin high halts sensing and outputs.
// - Pin low resumes; data valid after 6 ms.
// - No serial answers while pin holds sleep.
// - Enable bit one duty cycles, zero continuous.
// - Active 0.94 ms; inactive 120 to 960 ms.
// - Output bit one keeps only serial outputs during naps.
// - Serial answers in run and naps only; position refreshed per wake.
`ifndef POWER_SAVE_MAP_VH
`define POWER_SAVE_MAP_VH
`define CLK_HZ 40000000
`define WAKE_SETTLE_US 6000
`define ACTIVE_TIME_NS 940000
`define INACTIVE_BASE_MS 120
`define WAKE_SETTLE_CYC ((`WAKE_SETTLE_US * (`CLK_HZ / 1000000)))
`define ACTIVE_CYC ((`ACTIVE_TIME_NS / 25))
`define INACTIVE_BASE_CYC ((`INACTIVE_BASE_MS * (`CLK_HZ / 1000)))
`define CNT_W 26
`endif

// ===== src/pin_sync.v
`timescale 1ns/1ps
module pin_sync (
    input wire clk_sys,
    input wire rst,
    input wire pin,
    output wire level
);
    reg stage1;
    reg stage2;
    // Reset to asleep so nothing runs before the pin is really seen low.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
        end
    end
    assign level = stage2;
endmodule // pin_sync

// ===== src/power_save_sequencer.v
`timescale 1ns/1ps
`include "power_save_map.vh"
module power_save_sequencer #(
    parameter [25:0] SETTLE_CYC = `WAKE_SETTLE_CYC,
    parameter [25:0] ACTIVE_CYC = `ACTIVE_CYC,
    parameter [25:0] INACTIVE_BASE_CYC = `INACTIVE_BASE_CYC
) (
    input wire clk_sys,
    input wire rst,
    input wire sleep_request_pin,
    input wire auto_sleep_enable,
    input wire [1:0] sleep_period,
    input wire serial_only,
    input wire position_done,
    output reg core_run,
    output reg serial_enable,
    output reg other_outputs_enable,
    output reg position_valid,
    output reg position_latch
);
    localparam [3:0] ST_SLEEP = 4'b0001;
    localparam [3:0] ST_SETTLE = 4'b0010;
    localparam [3:0] ST_RUN = 4'b0100;
    localparam [3:0] ST_NAP = 4'b1000;

    wire pin_high;
    reg [3:0] state;
    reg [3:0] next_state;
    reg [`CNT_W-1:0] count;
    reg [`CNT_W-1:0] next_count;
    reg fresh;
    reg [`CNT_W-1:0] nap_cyc;
    reg next_core_run;
    reg next_serial_enable;
    reg next_other_outputs_enable;
    reg next_position_valid;
    reg next_position_latch;
    reg next_fresh;
    wire taking;

    pin_sync u_pin_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(sleep_request_pin),
        .level(pin_high)
    );

    ////////////////////////////////////////////////////////////////////////
    // Inactive time doubles per step of the period field.
    // Each step of the period field doubles the nap; the widest still fits the counter.
    always @* begin
        case (sleep_period)
            2'h0: nap_cyc = INACTIVE_BASE_CYC;
            2'h1: nap_cyc = INACTIVE_BASE_CYC << 1;
            2'h2: nap_cyc = INACTIVE_BASE_CYC << 2;
            default: nap_cyc = INACTIVE_BASE_CYC << 3;
        endcase
    end

    // A position is only taken while the core is really active.
    assign taking = (state == ST_RUN) && position_done;

    always @* begin
        next_state = state;
        next_count = count;
        case (state)
            ST_SLEEP: begin
                next_count = {`CNT_W{1'b0}};
                if (!pin_high) begin
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                next_count = count + 1'b1;
                if (count == SETTLE_CYC - 1'b1) begin
                    next_state = ST_RUN;
                    next_count = {`CNT_W{1'b0}};
                end
            end
            ST_RUN: begin
                if (auto_sleep_enable) begin
                    next_count = count + 1'b1;
                    if (count == ACTIVE_CYC - 1'b1) begin
                        next_state = ST_NAP;
                        next_count = {`CNT_W{1'b0}};
                    end
                end else begin
                    next_count = {`CNT_W{1'b0}};
                end
            end
            ST_NAP: begin
                next_count = count + 1'b1;
                if (!auto_sleep_enable || count >= nap_cyc - 1'b1) begin
                    next_state = ST_RUN;
                    next_count = {`CNT_W{1'b0}};
                end
            end
            default: begin
                next_state = ST_SLEEP;
                next_count = {`CNT_W{1'b0}};
            end
        endcase
        // The pin overrides every state; the host is trusted to keep it low
        // while duty cycling, so no arbitration with the timer is attempted.
        if (pin_high) begin
            next_state = ST_SLEEP;
            next_count = {`CNT_W{1'b0}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs other than position_latch follow the state being entered, so they change together with it.
    always @* begin
        next_core_run = 1'b0;
        next_serial_enable = 1'b0;
        next_other_outputs_enable = 1'b0;
        next_fresh = fresh;
        case (next_state)
            ST_SLEEP: begin
                next_fresh = 1'b0;
            end
            ST_SETTLE: begin
                // Position computed during settle is not trusted yet.
                next_core_run = 1'b1;
                next_fresh = 1'b0;
            end
            ST_RUN: begin
                next_core_run = 1'b1;
                next_serial_enable = 1'b1;
                next_other_outputs_enable = 1'b1;
                if (taking) begin
                    next_fresh = 1'b1;
                end
            end
            ST_NAP: begin
                // Serial ports keep answering in naps with the last latched position.
                next_serial_enable = 1'b1;
                next_other_outputs_enable = !serial_only;
                if (taking) begin
                    next_fresh = 1'b1;
                end
            end
            default: begin
                next_fresh = 1'b0;
            end
        endcase
        next_position_valid = ((next_state == ST_RUN) || (next_state == ST_NAP))
            && next_fresh;
        next_position_latch = taking;
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_SLEEP;
            count <= {`CNT_W{1'b0}};
            fresh <= 1'b0;
            core_run <= 1'b0;
            serial_enable <= 1'b0;
            other_outputs_enable <= 1'b0;
            position_valid <= 1'b0;
            position_latch <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            fresh <= next_fresh;
            core_run <= next_core_run;
            serial_enable <= next_serial_enable;
            other_outputs_enable <= next_other_outputs_enable;
            position_valid <= next_position_valid;
            position_latch <= next_position_latch;
        end
    end
endmodule // power_save_sequencer

// ===== tb/power_save_checker.sv
`timescale 1ns/1ps
module power_save_checker #(parameter [25:0] SETTLE_CYC = 26'd20, ACTIVE_CYC = 26'd10,
    INACTIVE_BASE_CYC = 26'd30) (input wire clk_sys, rst, sleep_request_pin,
    auto_sleep_enable, serial_only, position_done, core_run, serial_enable,
    other_outputs_enable, position_valid, position_latch);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Four pin samples cover the two-flop synchroniser plus the state register.
    halt_a: assert property (sleep_request_pin [*4] |-> !core_run)
        else $error("core runs asleep");
    settle_a: assert property ($rose(core_run) && !serial_enable |=> !serial_enable [*8])
        else $error("serial early");
    mute_a: assert property (sleep_request_pin [*4] |-> !serial_enable)
        else $error("serial asleep");
    cont_a: assert property (!sleep_request_pin [*3] ##0 (core_run && !auto_sleep_enable) |=> core_run)
        else $error("core stopped");
    wake_a: assert property ($rose(core_run) && serial_enable && auto_sleep_enable |-> core_run [*8])
        else $error("wake short");
    outsel_a: assert property ($fell(core_run) && serial_enable |-> other_outputs_enable != serial_only)
        else $error("nap outputs");
    fresh_a: assert property (position_done && core_run && serial_enable |=> position_latch)
        else $error("no latch");
    dark_a: assert property (sleep_request_pin [*4] |-> !position_valid)
        else $error("valid asleep");
    cover property ($fell(core_run) && serial_enable);
    cover property (position_latch);
    cover property ($rose(serial_enable));
endmodule // power_save_checker
bind power_save_sequencer power_save_checker #(.SETTLE_CYC(SETTLE_CYC), .ACTIVE_CYC(ACTIVE_CYC),
    .INACTIVE_BASE_CYC(INACTIVE_BASE_CYC)) u_chk (.*);

// ===== tb/host_pin_model.sv
`timescale 1ns/1ps
module host_pin_model (input wire sleep_cmd, input wire auto_sleep_enable, output wire sleep_request_pin);
    // The pin has no pull, so the host always drives a level, low while duty cycling.
    assign sleep_request_pin = sleep_cmd & ~auto_sleep_enable;
endmodule // host_pin_model

// ===== tb/power_save_sequencer_tb_top.sv
`timescale 1ns/1ps
module power_save_sequencer_tb_top;
    reg clk_sys = 0, rst = 1, cmd = 1, auto = 0, sel = 0, done = 0;
    reg [1:0] per = 2'h0;
    wire pin, run, ser, oth, val, lat;
    integer fail_count = 0, check_count = 0, cyc = 0, n, p;
    always #12.5 clk_sys = ~clk_sys;
    host_pin_model u_host (.sleep_cmd(cmd), .auto_sleep_enable(auto), .sleep_request_pin(pin));
    power_save_sequencer #(.SETTLE_CYC(26'd20), .ACTIVE_CYC(26'd10), .INACTIVE_BASE_CYC(26'd30))
        u_dut (.clk_sys(clk_sys), .rst(rst), .sleep_request_pin(pin), .auto_sleep_enable(auto),
        .sleep_period(per), .serial_only(sel), .position_done(done), .core_run(run),
        .serial_enable(ser), .other_outputs_enable(oth), .position_valid(val), .position_latch(lat));
    task chk(input logic s, input logic e); begin
        check_count = check_count + 1;
        if (s !== e) begin fail_count = fail_count + 1; $display("BAD %0t mismatch", $time); end
    end endtask
    task tick(input integer k); begin repeat (k) @(posedge clk_sys); #1; end endtask
    task pulse; begin done = 1; tick(1); done = 0; end endtask
    task results; begin
        $display("checks %0d fails %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    end endtask
    task t_wake; begin
        cmd = 0; tick(5); chk(run, 1);
        pulse; chk(lat, 0); tick(15); chk(ser, 0); chk(val, 0);
        tick(5); chk(ser, 1); chk(oth, 1);
        pulse; chk(lat, 1); chk(val, 1); tick(60); chk(run, 1);
    end endtask
    task t_sleep; begin
        cmd = 1; tick(4); chk(run, 0); chk(ser, 0); chk(val, 0);
    end endtask
    task t_auto(input integer q); begin
        per = q; sel = q % 2; auto = 1; n = 0;
        while ((!ser || run) && n < 200) begin tick(1); n = n + 1; end
        chk(ser, 1); chk(oth, !sel); n = 0;
        while (!run && n < 2000) begin tick(1); n = n + 1; end
        chk(n >= (30 << q) - 1 && n <= (30 << q) + 2, 1);
        pulse; chk(lat, 1); n = 1;
        while (run && n < 100) begin tick(1); n = n + 1; end
        chk(n >= 9 && n <= 12, 1); auto = 0; tick(4); chk(run, 0);
    end endtask
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin fail_count = fail_count + 1; results; end
    end
    initial begin
        tick(4); rst = 0;
        t_wake;
        t_sleep;
        for (p = 0; p < 4; p = p + 1) t_auto(p);
        results;
    end
endmodule // power_save_sequencer_tb_top
